// ==== pkg/cmti_pkg.sv ====
// Purpose: shared constants, types and helpers of the colour measure timing and interrupt block
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes: register offsets are byte addresses of the sensor's command-addressed register space
// Summary of operation
// R1: no measurement starts until one full 2.4 ms step has passed after the power-on bit is set.
// R2: integration lasts 256 minus the integration-time value steps of 2.4 ms each.
// R3: the maximum channel count is the integration step count times 1024, saturating at 65535.
// R4: the wait period is counted in 2.4 ms steps, each twelve times longer when long wait is set.
// R5: the wait step count is 256 minus the wait-time value, read as two's complement.
// R6: the low threshold is the byte at 0x04 below the byte at 0x05.
// R7: the high threshold is the byte at 0x06 below the byte at 0x07.
// R8: only the clear result is compared, and a value below low or above high is out of range.
// R9: the persistence setting sits in bits 3:0 of the filter register at 0x0C, bits 7:4 reserved.
// R10: setting 0000 raises an interrupt at the end of every measurement.
// R11: setting 0001 raises an interrupt on a single out-of-range result.
// R12: settings 2 and 3 need that many consecutive out-of-range results, 4 to 15 need 5 to 60 in steps of 5.
// R13: long wait is bit 1 of the configuration register at 0x0D and multiplies the wait by 12.
// R14: status bit 4 shows a pending clear-channel interrupt.
// R15: status bit 0 is set once an integration cycle has completed.
// R16: an in-range result resets the consecutive out-of-range counter.
// R17: the interrupt stays until the clear command, which also resets the persistence counter.
package cmti_pkg;
  localparam int unsigned CLK_FREQ_KHZ = 10000;
  localparam int unsigned TIMEBASE_US = 2400;
  localparam int unsigned STEP_CYCLES = (TIMEBASE_US * CLK_FREQ_KHZ + 999) / 1000;

  localparam logic [4:0] ADDR_ENABLE = 5'h00;
  localparam logic [4:0] ADDR_ITIME = 5'h01;
  localparam logic [4:0] ADDR_WAIT_TIME = 5'h03;
  localparam logic [4:0] ADDR_LOW_LO = 5'h04;
  localparam logic [4:0] ADDR_LOW_HI = 5'h05;
  localparam logic [4:0] ADDR_HIGH_LO = 5'h06;
  localparam logic [4:0] ADDR_HIGH_HI = 5'h07;
  localparam logic [4:0] ADDR_FILTER = 5'h0C;
  localparam logic [4:0] ADDR_CONFIG = 5'h0D;
  localparam logic [4:0] ADDR_STATUS = 5'h13;
  localparam logic [4:0] ADDR_CLEAR_LO = 5'h14;
  localparam logic [4:0] ADDR_CLEAR_HI = 5'h15;

  localparam int unsigned EN_POWER_ON_BIT = 0;
  localparam int unsigned EN_MEASURE_BIT = 1;
  localparam int unsigned EN_WAIT_BIT = 3;
  localparam int unsigned EN_IRQ_BIT = 4;
  localparam int unsigned CFG_LONG_WAIT_BIT = 1;
  localparam int unsigned ST_IRQ_BIT = 4;
  localparam int unsigned ST_VALID_BIT = 0;

  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_ITIME = 8'hFF;
  localparam logic [7:0] RST_WAIT_TIME = 8'hFF;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_FILTER = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] FILTER_MASK = 8'h0F;
  localparam logic [7:0] CONFIG_MASK = 8'h02;

  localparam logic [8:0] STEP_BASE = 9'h100;
  localparam logic [8:0] SAT_STEPS = 9'h040;
  localparam logic [15:0] MAX_COUNT_SAT = 16'hFFFF;
  localparam logic [3:0] LONG_WAIT_LAST = 4'hB;
  localparam logic [5:0] PERSIST_CNT_MAX = 6'h3F;

  typedef struct packed {
    logic wr;
    logic rd;
    logic clear_cmd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } cmti_reg_req_s;

  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_PWRUP = 5'b00010,
    ST_IDLE = 5'b00100,
    ST_INTEG = 5'b01000,
    ST_WAIT = 5'b10000
  } cmti_state_e;

  // consecutive out-of-range results needed per persistence setting
  function automatic logic [5:0] persist_need(input logic [3:0] setting);
    logic [5:0] need;
    need = 6'h00;
    if (setting < 4'h4) begin
      need = {2'b00, setting};
    end else begin
      need = 6'((setting - 4'h3) * 5);
    end
    return need;
  endfunction
endpackage

// ==== hdl/cmti_timebase.sv ====
// Purpose: free step timebase giving one tick per 2.4 ms step
// Assumes: restart realigns the step so that a new phase gets full steps
// Notes: STEP_CYCLES is overridable so simulation can shorten the step
module cmti_timebase #(
  parameter int unsigned STEP_CYCLES = cmti_pkg::STEP_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic restart, // start a fresh step
  output logic tick // one-cycle pulse at end of each step
);
  localparam int unsigned W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(STEP_CYCLES - 1);
  logic [W-1:0] cnt;

  always_ff @(posedge clk) begin
    if (sys_rst || restart || cnt == LAST) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || restart) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt == LAST);
    end
  end
endmodule

// ==== hdl/cmti_persist.sv ====
// Purpose: persistence filter between clear-channel comparison and the interrupt flag
// Assumes: strobe is one cycle per completed measurement
// Notes: counter saturates so a long run out of range keeps firing
module cmti_persist (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic strobe, // measurement complete
  input wire logic out_of_range, // clear result outside thresholds
  input wire logic [3:0] setting, // persistence setting
  input wire logic flush, // interrupt clear command
  output logic fire // one-cycle interrupt request
);
  logic [5:0] cnt;
  logic [5:0] base;
  logic [5:0] next_cnt;

  always_comb begin
    base = flush ? 6'h00 : cnt; // R17
    next_cnt = base;
    if (strobe) begin
      if (!out_of_range) begin
        next_cnt = 6'h00; // R16
      end else if (base != cmti_pkg::PERSIST_CNT_MAX) begin
        next_cnt = base + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= 6'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fire <= 1'b0;
    end else if (strobe && setting == 4'h0) begin
      fire <= 1'b1; // R10
    end else begin
      fire <= strobe && out_of_range && next_cnt >= cmti_pkg::persist_need(setting); // R11 R12
    end
  end
endmodule

// ==== hdl/cmti_top.sv ====
// Purpose: measurement sequencing, threshold compare and interrupt of a colour light sensor
// Assumes: register requests arrive already decoded from the serial command layer
// Notes: the clear count input comes from the accumulator on the same clock
module cmti_top #(
  parameter int unsigned STEP_CYCLES = cmti_pkg::STEP_CYCLES
) (
  input wire logic clk, // 10 MHz system clock
  input wire logic sys_rst, // synchronous active-high reset
  input wire cmti_pkg::cmti_reg_req_s reg_req, // decoded register access
  output logic [7:0] reg_rdata, // read data, one cycle after rd
  output logic reg_rvalid, // read data valid pulse
  input wire logic [15:0] clear_count, // clear accumulator value
  output logic integ_active, // integration window to the converters
  output logic meas_done, // pulse at end of each integration
  output logic [15:0] max_count, // largest attainable channel count
  output logic [15:0] clear_result, // last clamped clear result
  input wire logic int_pin_i, // interrupt pin level
  output logic int_pin_o, // interrupt pin drive value
  output logic int_pin_oe // interrupt pin drive enable
);
  logic [7:0] enable_control;
  logic [7:0] integration_time;
  logic [7:0] wait_time;
  logic [7:0] low_threshold_lo;
  logic [7:0] low_threshold_hi;
  logic [7:0] high_threshold_lo;
  logic [7:0] high_threshold_hi;
  logic [7:0] interrupt_filter;
  logic [7:0] config_reg;
  logic clear_channel_irq_flag;
  logic measurement_valid_flag;
  logic pin_sync1;
  logic pin_sync2;

  cmti_pkg::cmti_state_e state;
  cmti_pkg::cmti_state_e next_state;
  logic [8:0] step_cnt;
  logic [3:0] sub_cnt;
  logic tick;
  logic restart;
  logic fire;

  logic power_on_bit;
  logic measure_en;
  logic wait_en;
  logic irq_en;
  logic long_wait_bit;
  logic [3:0] persistence_setting;
  logic [8:0] integ_steps;
  logic [8:0] wait_steps;
  logic [15:0] low_thr;
  logic [15:0] high_thr;
  logic [15:0] clamped;
  logic out_of_range;
  logic integ_end;
  logic wait_end;
  logic [15:0] next_max;

  assign power_on_bit = enable_control[cmti_pkg::EN_POWER_ON_BIT];
  assign measure_en = enable_control[cmti_pkg::EN_MEASURE_BIT];
  assign wait_en = enable_control[cmti_pkg::EN_WAIT_BIT];
  assign irq_en = enable_control[cmti_pkg::EN_IRQ_BIT];
  assign long_wait_bit = config_reg[cmti_pkg::CFG_LONG_WAIT_BIT]; // R13
  assign persistence_setting = interrupt_filter[3:0]; // R9
  assign integ_steps = cmti_pkg::STEP_BASE - {1'b0, integration_time}; // R2
  assign wait_steps = cmti_pkg::STEP_BASE - {1'b0, wait_time}; // R5
  assign low_thr = {low_threshold_hi, low_threshold_lo}; // R6
  assign high_thr = {high_threshold_hi, high_threshold_lo}; // R7

  // a hit is a write request to this byte address; reads are decoded separately
  function automatic logic hit(input cmti_pkg::cmti_reg_req_s req, input logic [4:0] addr);
    return req.wr && req.addr == addr;
  endfunction

  always_comb begin
    if (integ_steps >= cmti_pkg::SAT_STEPS) begin
      next_max = cmti_pkg::MAX_COUNT_SAT; // R3
    end else begin
      next_max = {integ_steps[5:0], 10'h000}; // R3
    end
  end

  assign clamped = (clear_count > max_count) ? max_count : clear_count;
  assign out_of_range = clamped < low_thr || clamped > high_thr; // R8
  assign integ_end = state == cmti_pkg::ST_INTEG && tick && step_cnt == integ_steps - 9'h001;
  assign wait_end = state == cmti_pkg::ST_WAIT && tick && step_cnt == wait_steps - 9'h001 &&
                    (!long_wait_bit || sub_cnt == cmti_pkg::LONG_WAIT_LAST);

  // register file
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_control <= cmti_pkg::RST_ENABLE;
    end else if (hit(reg_req, cmti_pkg::ADDR_ENABLE)) begin
      enable_control <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      integration_time <= cmti_pkg::RST_ITIME;
      wait_time <= cmti_pkg::RST_WAIT_TIME;
    end else begin
      if (hit(reg_req, cmti_pkg::ADDR_ITIME)) begin
        integration_time <= reg_req.wdata;
      end
      if (hit(reg_req, cmti_pkg::ADDR_WAIT_TIME)) begin
        wait_time <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_threshold_lo <= cmti_pkg::RST_THRESHOLD;
      low_threshold_hi <= cmti_pkg::RST_THRESHOLD;
      high_threshold_lo <= cmti_pkg::RST_THRESHOLD;
      high_threshold_hi <= cmti_pkg::RST_THRESHOLD;
    end else begin
      if (hit(reg_req, cmti_pkg::ADDR_LOW_LO)) begin
        low_threshold_lo <= reg_req.wdata; // R6
      end
      if (hit(reg_req, cmti_pkg::ADDR_LOW_HI)) begin
        low_threshold_hi <= reg_req.wdata; // R6
      end
      if (hit(reg_req, cmti_pkg::ADDR_HIGH_LO)) begin
        high_threshold_lo <= reg_req.wdata; // R7
      end
      if (hit(reg_req, cmti_pkg::ADDR_HIGH_HI)) begin
        high_threshold_hi <= reg_req.wdata; // R7
      end
    end
  end

  // reserved bits are never stored so they always read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      interrupt_filter <= cmti_pkg::RST_FILTER;
      config_reg <= cmti_pkg::RST_CONFIG;
    end else begin
      if (hit(reg_req, cmti_pkg::ADDR_FILTER)) begin
        interrupt_filter <= reg_req.wdata & cmti_pkg::FILTER_MASK; // R9
      end
      if (hit(reg_req, cmti_pkg::ADDR_CONFIG)) begin
        config_reg <= reg_req.wdata & cmti_pkg::CONFIG_MASK; // R13
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        unique case (reg_req.addr)
          cmti_pkg::ADDR_ENABLE: reg_rdata <= enable_control;
          cmti_pkg::ADDR_ITIME: reg_rdata <= integration_time;
          cmti_pkg::ADDR_WAIT_TIME: reg_rdata <= wait_time;
          cmti_pkg::ADDR_LOW_LO: reg_rdata <= low_threshold_lo;
          cmti_pkg::ADDR_LOW_HI: reg_rdata <= low_threshold_hi;
          cmti_pkg::ADDR_HIGH_LO: reg_rdata <= high_threshold_lo;
          cmti_pkg::ADDR_HIGH_HI: reg_rdata <= high_threshold_hi;
          cmti_pkg::ADDR_FILTER: reg_rdata <= interrupt_filter;
          cmti_pkg::ADDR_CONFIG: reg_rdata <= config_reg;
          cmti_pkg::ADDR_STATUS: begin
            reg_rdata <= {3'b000, clear_channel_irq_flag, 3'b000, measurement_valid_flag}; // R14 R15
          end
          cmti_pkg::ADDR_CLEAR_LO: reg_rdata <= clear_result[7:0];
          cmti_pkg::ADDR_CLEAR_HI: reg_rdata <= clear_result[15:8];
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // measurement sequencer
  cmti_timebase #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timebase (
    .clk(clk),
    .sys_rst(sys_rst),
    .restart(restart),
    .tick(tick)
  );

  always_comb begin
    next_state = state;
    restart = 1'b0;
    if (!power_on_bit) begin
      next_state = cmti_pkg::ST_OFF;
    end else begin
      unique case (state)
        cmti_pkg::ST_OFF: begin
          next_state = cmti_pkg::ST_PWRUP;
          restart = 1'b1;
        end
        cmti_pkg::ST_PWRUP: begin
          if (tick) begin
            next_state = cmti_pkg::ST_IDLE; // R1
          end
        end
        cmti_pkg::ST_IDLE: begin
          if (measure_en) begin
            next_state = cmti_pkg::ST_INTEG;
            restart = 1'b1;
          end
        end
        cmti_pkg::ST_INTEG: begin
          if (integ_end) begin
            restart = 1'b1;
            if (!measure_en) begin
              next_state = cmti_pkg::ST_IDLE;
            end else if (wait_en) begin
              next_state = cmti_pkg::ST_WAIT;
            end
          end
        end
        cmti_pkg::ST_WAIT: begin
          if (wait_end) begin
            restart = 1'b1;
            next_state = measure_en ? cmti_pkg::ST_INTEG : cmti_pkg::ST_IDLE;
          end
        end
        default: begin
          next_state = cmti_pkg::ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= cmti_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // step and long-wait sub-step counters, cleared on every phase change
  always_ff @(posedge clk) begin
    if (sys_rst || restart || state == cmti_pkg::ST_OFF) begin
      step_cnt <= 9'h000;
      sub_cnt <= 4'h0;
    end else if (tick && state == cmti_pkg::ST_INTEG) begin
      step_cnt <= step_cnt + 9'h001; // R2
    end else if (tick && state == cmti_pkg::ST_WAIT) begin
      if (long_wait_bit && sub_cnt != cmti_pkg::LONG_WAIT_LAST) begin
        sub_cnt <= sub_cnt + 4'h1; // R4
      end else begin
        sub_cnt <= 4'h0;
        step_cnt <= step_cnt + 9'h001; // R4 R5
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      max_count <= 16'h0000;
    end else begin
      max_count <= next_max; // R3
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clear_result <= 16'h0000;
      meas_done <= 1'b0;
    end else begin
      meas_done <= integ_end;
      if (integ_end) begin
        clear_result <= clamped;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || state == cmti_pkg::ST_OFF) begin
      measurement_valid_flag <= 1'b0;
    end else if (integ_end) begin
      measurement_valid_flag <= 1'b1; // R15
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      integ_active <= 1'b0;
    end else begin
      integ_active <= next_state == cmti_pkg::ST_INTEG;
    end
  end

  // interrupt path
  cmti_persist u_persist (
    .clk(clk),
    .sys_rst(sys_rst),
    .strobe(integ_end),
    .out_of_range(out_of_range),
    .setting(persistence_setting),
    .flush(reg_req.clear_cmd),
    .fire(fire)
  );

  // a request in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clear_channel_irq_flag <= 1'b0;
    end else if (fire) begin
      clear_channel_irq_flag <= 1'b1; // R14
    end else if (reg_req.clear_cmd) begin
      clear_channel_irq_flag <= 1'b0; // R17
    end
  end

  // pin level kept for observation only; pulled high outside
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_sync1 <= 1'b1;
      pin_sync2 <= 1'b1;
    end else begin
      pin_sync1 <= int_pin_i;
      pin_sync2 <= pin_sync1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_pin_o <= 1'b0;
      int_pin_oe <= 1'b0;
    end else begin
      int_pin_o <= 1'b0;
      int_pin_oe <= clear_channel_irq_flag && irq_en; // R14 R17
    end
  end
endmodule

// ==== verif/cmti_top_chk.sv ====
// Purpose: port checker for cmti_top
// Assumes: register writes seen on reg_req reach the block unchanged
// Notes: snoops power-on and integration-time writes to form expectations
module cmti_top_chk #(
  parameter int unsigned STEP_CYCLES = 8
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset
  input wire cmti_pkg::cmti_reg_req_s reg_req, // register access
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rvalid, // read valid
  input wire logic [15:0] clear_count, // clear accumulator
  input wire logic integ_active, // integration window
  input wire logic meas_done, // end of integration
  input wire logic [15:0] max_count, // max count
  input wire logic [15:0] clear_result, // clamped result
  input wire logic int_pin_i, // pin level
  input wire logic int_pin_o, // pin drive value
  input wire logic int_pin_oe // pin drive enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] itime_q;
  logic pon_q;
  logic it_wr;
  int pon_cnt;
  int run_cnt;
  int steps;
  int s_c;
  assign it_wr = reg_req.wr && reg_req.addr == cmti_pkg::ADDR_ITIME;
  assign steps = 256 - int'(itime_q);
  assign s_c = int'(STEP_CYCLES);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      itime_q <= 8'hFF;
    end else if (it_wr) begin
      itime_q <= reg_req.wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pon_q <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == cmti_pkg::ADDR_ENABLE) begin
      pon_q <= reg_req.wdata[0];
    end
  end
  // saturate so a long run never wraps into a false early start
  always_ff @(posedge clk) begin
    if (sys_rst || !pon_q) begin
      pon_cnt <= 0;
    end else if (pon_cnt < 100000) begin
      pon_cnt <= pon_cnt + 1;
    end
  end
  // restart per measurement, back-to-back integrations keep the window high
  always_ff @(posedge clk) begin
    if (sys_rst || !integ_active || meas_done) begin
      run_cnt <= 0;
    end else begin
      run_cnt <= run_cnt + 1;
    end
  end
  a_read_answer: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  a_read_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_pin_open_drain: assert property (int_pin_oe |-> !int_pin_o)
    else $error("interrupt pin driven high");
  a_pwrup_gap: assert property ($rose(integ_active) |-> pon_cnt >= s_c)
    else $error("integration began before power-up step");
  a_integ_length: assert property (meas_done |->
    run_cnt >= steps * s_c - 1 && run_cnt <= steps * s_c + 2)
    else $error("integration length wrong");
  a_max_count: assert property (!$past(sys_rst) && !$past(it_wr) |->
    max_count == (steps >= 64 ? 16'hFFFF : 16'(steps * 1024)))
    else $error("max count wrong");
  a_result_clamp: assert property (meas_done |->
    clear_result == ($past(clear_count) > $past(max_count) ? $past(max_count) : $past(clear_count)))
    else $error("clear result not clamped count");
  a_done_ends_integ: assert property (meas_done |-> $past(integ_active))
    else $error("done without integration");
  a_irq_clear: assert property (reg_req.clear_cmd && !meas_done && !$past(meas_done)
    && !$past(meas_done, 2) |-> ##2 !int_pin_oe)
    else $error("interrupt survived clear");
  a_irq_hold: assert property ($fell(int_pin_oe) |-> $past(reg_req.clear_cmd, 2)
    || $past(reg_req.wr, 2) || $past(reg_req.wr))
    else $error("interrupt dropped without clear");
  a_irq_cause: assert property ($rose(int_pin_oe) |-> $past(meas_done)
    || $past(meas_done, 2) || $past(meas_done, 3) || $past(reg_req.wr, 2))
    else $error("interrupt without measurement");
endmodule

bind cmti_top cmti_top_chk #(.STEP_CYCLES(STEP_CYCLES)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .clear_count(clear_count), .integ_active(integ_active),
  .meas_done(meas_done), .max_count(max_count), .clear_result(clear_result),
  .int_pin_i(int_pin_i), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe)
);

// ==== verif/cmti_light_model.sv ====
// Purpose: light source and clear accumulator facing cmti_top
// Assumes: the bench sets the light level; interrupt line has a pull-up
// Notes: count follows light only while integrating, then freezes
module cmti_light_model (
  input wire logic clk, // system clock
  input wire logic integ_active, // integration window
  input wire logic [15:0] light, // light level from the bench
  input wire logic int_o, // pin drive value
  input wire logic int_oe, // pin drive enable
  output logic [15:0] clear_count, // accumulator output
  output logic int_level // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial clear_count = 16'h0000;
  always @(posedge clk) begin
    if (integ_active) begin
      clear_count <= light;
    end
  end
  assign int_level = int_oe ? int_o : 1'b1;
endmodule

// ==== verif/cmti_top_tb_top.sv ====
// Purpose: self-checking bench for cmti_top
// Assumes: step shortened to ST cycles; inputs change at the falling edge
// Notes: expectations come from the register and persistence tables
module cmti_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 8;
  logic clk;
  logic sys_rst;
  cmti_pkg::cmti_reg_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic [15:0] light;
  logic [15:0] ccount;
  logic integ;
  logic done;
  logic [15:0] maxc;
  logic [15:0] cres;
  logic int_lvl;
  logic int_o;
  logic int_oe;
  int err_count = 0;
  int num_checks = 0;
  int cyc;
  int n;
  logic [4:0] ra [10] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0C, 5'h0D, 5'h02};
  logic [7:0] rv [10] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] it [5] = '{8'hFF, 8'hF6, 8'hC1, 8'hC0, 8'h00};
  logic [15:0] mc [5] = '{16'h0400, 16'h2800, 16'hFC00, 16'hFFFF, 16'hFFFF};
  logic [7:0] td [4] = '{8'h00, 8'h01, 8'h00, 8'h02};

  cmti_top #(.STEP_CYCLES(ST)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .clear_count(ccount), .integ_active(integ), .meas_done(done), .max_count(maxc),
    .clear_result(cres), .int_pin_i(int_lvl), .int_pin_o(int_o), .int_pin_oe(int_oe)
  );
  cmti_light_model model_u (
    .clk(clk), .integ_active(integ), .light(light), .int_o(int_o), .int_oe(int_oe),
    .clear_count(ccount), .int_level(int_lvl)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out();
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    req = {1'b1, 1'b0, 1'b0, a, d};
    @(negedge clk);
    req = '0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    @(negedge clk);
    req = {1'b0, 1'b1, 1'b0, a, 8'h00};
    @(negedge clk);
    req = '0;
    chk("read valid", 16'h0001, 16'(rvalid));
    chk($sformatf("reg %h", a), 16'(e), 16'(rdata));
  endtask

  // clear then let the flag and pin drop before anyone samples them
  task automatic clr();
    @(negedge clk);
    req = {1'b0, 1'b0, 1'b1, 5'h00, 8'h00};
    @(negedge clk);
    req = '0;
    idle(2);
  endtask

  task automatic wait_done(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (done !== 1'b1 && c < 2000);
    if (c >= 2000) begin
      $display("CHECK FAILED measurement done expected 1 seen timeout");
      err_count++;
      close_out();
    end
  endtask

  initial begin
    req = '0;
    light = 16'h0150;
    sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 10; i++) rd_chk(ra[i], rv[i]);
    wr_reg(5'h0C, 8'hFF);
    rd_chk(5'h0C, 8'h0F);
    wr_reg(5'h0D, 8'hFF);
    rd_chk(5'h0D, 8'h02);
    wr_reg(5'h0D, 8'h00);
    wr_reg(5'h0C, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr_reg(5'h01, it[i]);
      idle(2);
      chk("max count", mc[i], maxc);
    end
    for (int i = 0; i < 4; i++) wr_reg(5'(4 + i), td[i]);
    for (int i = 0; i < 4; i++) rd_chk(5'(4 + i), td[i]);
    wr_reg(5'h01, 8'hFE);
    wr_reg(5'h00, 8'h13);
    idle(ST);
    chk("early integration", 16'h0000, 16'(integ));
    wait_done(cyc);
    idle(3);
    rd_chk(5'h13, 8'h11);
    chk("pin enable", 16'h0001, 16'(int_oe));
    chk("clear result", 16'h0150, cres);
    clr();
    rd_chk(5'h13, 8'h01);
    chk("pin enable", 16'h0000, 16'(int_oe));
    light = 16'h0050;
    for (int s = 1; s < 16; s++) begin
      wait_done(cyc);
      idle(3);
      wr_reg(5'h0C, 8'(s));
      clr();
      n = 0;
      cyc = 0;
      while (int_oe !== 1'b1 && cyc < 2000) begin
        @(negedge clk);
        cyc++;
        if (done === 1'b1) n++;
      end
      if (cyc >= 2000) begin
        $display("CHECK FAILED persistence interrupt expected 1 seen timeout");
        err_count++;
        close_out();
      end
      chk("persistence count", 16'(s < 4 ? s : (s - 3) * 5), 16'(n));
    end
    wait_done(cyc);
    idle(3);
    wr_reg(5'h0C, 8'h03);
    clr();
    wait_done(cyc);
    wait_done(cyc);
    light = 16'h0150;
    wait_done(cyc);
    light = 16'h0300;
    wait_done(cyc);
    wait_done(cyc);
    idle(3);
    rd_chk(5'h13, 8'h01);
    wait_done(cyc);
    idle(3);
    rd_chk(5'h13, 8'h11);
    light = 16'h5000;
    wait_done(cyc);
    wait_done(cyc);
    idle(2);
    chk("clamped result", 16'h0800, cres);
    rd_chk(5'h14, 8'h00);
    rd_chk(5'h15, 8'h08);
    wr_reg(5'h03, 8'hFE);
    wr_reg(5'h0D, 8'h02);
    wr_reg(5'h00, 8'h1B);
    wait_done(cyc);
    wait_done(cyc);
    wait_done(cyc);
    chk("long wait gap", 16'h0001, 16'(cyc >= 26 * ST - 2 && cyc <= 26 * ST + 4));
    wr_reg(5'h0D, 8'h00);
    wait_done(cyc);
    wait_done(cyc);
    wait_done(cyc);
    chk("short wait gap", 16'h0001, 16'(cyc >= 4 * ST - 2 && cyc <= 4 * ST + 4));
    wr_reg(5'h00, 8'h0B);
    wait_done(cyc);
    idle(3);
    chk("pin enable masked", 16'h0000, 16'(int_oe));
    rd_chk(5'h13, 8'h11);
    wr_reg(5'h00, 8'h00);
    idle(2);
    chk("integration after power off", 16'h0000, 16'(integ));
    rd_chk(5'h13, 8'h10);
    close_out();
  end
endmodule
